// File: logic/iop_pkg.sv
// Shared constants for the port pin and external bus multiplex logic
package iop_pkg;

  localparam int        PORT_W           = 8;
  localparam int        NUM_PORTS        = 4;
  localparam int        STRONG_PULSE_CYC = 2;

  localparam logic [7:0] LATCH_RST       = 8'hff;
  localparam logic [7:0] SYNC_RST        = 8'hff;

  localparam logic [1:0] PORT0           = 2'h0;
  localparam logic [1:0] PORT1           = 2'h1;
  localparam logic [1:0] PORT2           = 2'h2;
  localparam logic [1:0] PORT3           = 2'h3;

  localparam int        T3_EVENT_BIT     = 0;
  localparam int        T3_CTRL_BIT      = 1;
  localparam int        RXD_BIT          = 0;
  localparam int        TXD_BIT          = 1;
  localparam int        WR_BIT           = 6;
  localparam int        RD_BIT           = 7;

endpackage : iop_pkg

// File: logic/iop_qport_if.sv
// Carrier between the port top and one quasi-bidirectional port
`timescale 1ns/1ps
interface iop_qport_if #(
  parameter int W = iop_pkg::PORT_W
);
  logic [W-1:0] level;
  logic [W-1:0] force_strong;
  logic [W-1:0] pin_in;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe;
  logic [W-1:0] pin_sync;

  modport port (
    input  level,
    input  force_strong,
    input  pin_in,
    output pin_out,
    output pin_oe,
    output pin_sync
  );

  modport ctrl (
    output level,
    output force_strong,
    output pin_in,
    input  pin_out,
    input  pin_oe,
    input  pin_sync
  );
endinterface : iop_qport_if

// File: logic/iop_quasi_port.sv
// One quasi-bidirectional port: low drive, short strong high, weak pull-up
`timescale 1ns/1ps
module iop_quasi_port #(
  parameter int W     = iop_pkg::PORT_W,
  parameter int PULSE = iop_pkg::STRONG_PULSE_CYC
) (
  input wire logic  ref_clk,
  input wire logic  arst_n,
  iop_qport_if.port p
);
  import iop_pkg::*;

  if (PULSE < 1 || PULSE > 3 || W < 1 || W > 8) begin : g_bad_pulse
    $error("iop_quasi_port: PULSE must lie in 1..3 and W in 1..8");
  end

  typedef struct packed {
    logic [W-1:0]      sync1;
    logic [W-1:0]      sync2;
    logic [W-1:0]      prev;
    logic [W-1:0]      out;
    logic [W-1:0]      oe;
    logic [W-1:0][1:0] cnt;
  } iop_qp_state_s;

  iop_qp_state_s st_q;
  iop_qp_state_s st_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d       = st_q;
    st_d.sync1 = p.pin_in;
    st_d.sync2 = st_q.sync1;
    st_d.prev  = p.level;
    for (int i = 0; i < W; i++) begin
      if (!p.level[i]) begin
        st_d.out[i] = 1'b0;
        st_d.oe[i]  = 1'b1;
        st_d.cnt[i] = 2'h0;
      end else if (!st_q.prev[i]) begin
        // Rising level: strong high only briefly, pull-up does the rest
        st_d.out[i] = 1'b1;
        st_d.oe[i]  = 1'b1;
        st_d.cnt[i] = 2'(PULSE - 1);
      end else if (p.force_strong[i] || st_q.cnt[i] != 2'h0) begin
        st_d.out[i] = 1'b1;
        st_d.oe[i]  = 1'b1;
        st_d.cnt[i] = (st_q.cnt[i] != 2'h0) ? st_q.cnt[i] - 2'h1 : 2'h0;
      end else begin
        st_d.out[i] = 1'b1;
        st_d.oe[i]  = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q.sync1 <= SYNC_RST[W-1:0];
      st_q.sync2 <= SYNC_RST[W-1:0];
      st_q.prev  <= LATCH_RST[W-1:0];
      st_q.out   <= LATCH_RST[W-1:0];
      st_q.oe    <= '0;
      st_q.cnt   <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign p.pin_out  = st_q.out;
  assign p.pin_oe   = st_q.oe;
  assign p.pin_sync = st_q.sync2;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  for (genvar g = 0; g < W; g++) begin : g_chk
    sequence s_rise;
      $rose(p.level[g]) && !p.force_strong[g];
    endsequence
    sequence s_held_high;
      (p.level[g] && !p.force_strong[g]) [*2];
    endsequence
    a_strong_two_cycles: assert property ($rose(p.level[g]) |=> p.pin_oe[g] [*2])
      else $error("strong drive shorter than two cycles");
    a_pullup_after: assert property (s_rise ##1 s_held_high |=> !p.pin_oe[g])
      else $error("strong high drive lasted too long");
    a_low_drive: assert property (!p.level[g] |=> p.pin_oe[g] && !p.pin_out[g])
      else $error("zero latch not driven low");
  end

endmodule : iop_quasi_port

// File: logic/iop_ports.sv
// Four 8-bit port pins with external bus address/data multiplexing
`timescale 1ns/1ps
module iop_ports (
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  input  wire logic                         port_wr,
  input  wire logic [1:0]                   port_sel,
  input  wire logic [iop_pkg::PORT_W-1:0]   port_wdata,
  input  wire logic                         ext_bus_en,
  input  wire logic                         ext_addr_phase,
  input  wire logic [2*iop_pkg::PORT_W-1:0] ext_addr,
  input  wire logic                         ext_data_drive,
  input  wire logic [iop_pkg::PORT_W-1:0]   ext_wdata,
  input  wire logic                         ext_wr_strobe,
  input  wire logic                         ext_rd_strobe,
  input  wire logic                         timer3_clkout_en,
  input  wire logic                         timer3_clkout,
  input  wire logic                         uart_txd_en,
  input  wire logic                         uart_txd,
  input  wire logic [iop_pkg::PORT_W-1:0]   p0_in,
  input  wire logic [iop_pkg::PORT_W-1:0]   p1_in,
  input  wire logic [iop_pkg::PORT_W-1:0]   p2_in,
  input  wire logic [iop_pkg::PORT_W-1:0]   p3_in,
  output logic      [iop_pkg::PORT_W-1:0]   p0_out,
  output logic      [iop_pkg::PORT_W-1:0]   p0_oe,
  output logic      [iop_pkg::PORT_W-1:0]   p1_out,
  output logic      [iop_pkg::PORT_W-1:0]   p1_oe,
  output logic      [iop_pkg::PORT_W-1:0]   p2_out,
  output logic      [iop_pkg::PORT_W-1:0]   p2_oe,
  output logic      [iop_pkg::PORT_W-1:0]   p3_out,
  output logic      [iop_pkg::PORT_W-1:0]   p3_oe,
  output logic      [iop_pkg::PORT_W-1:0]   p0_pins,
  output logic      [iop_pkg::PORT_W-1:0]   p1_pins,
  output logic      [iop_pkg::PORT_W-1:0]   p2_pins,
  output logic      [iop_pkg::PORT_W-1:0]   p3_pins,
  output logic                              timer3_event_or_clkout,
  output logic                              timer3_ext_control,
  output logic                              uart_rxd
);
  import iop_pkg::*;

  typedef struct packed {
    logic [NUM_PORTS-1:0][PORT_W-1:0] latch;
    logic [PORT_W-1:0]                p0_out;
    logic [PORT_W-1:0]                p0_oe;
    logic [PORT_W-1:0]                p0_s1;
    logic [PORT_W-1:0]                p0_s2;
  } iop_top_state_s;

  iop_top_state_s    st_q;
  iop_top_state_s    st_d;
  logic [PORT_W-1:0] p1_lvl;
  logic [PORT_W-1:0] p2_lvl;
  logic [PORT_W-1:0] p2_frc;
  logic [PORT_W-1:0] p3_lvl;

  iop_qport_if #(.W(PORT_W)) p1_if ();
  iop_qport_if #(.W(PORT_W)) p2_if ();
  iop_qport_if #(.W(PORT_W)) p3_if ();

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d       = st_q;
    st_d.p0_s1 = p0_in;
    st_d.p0_s2 = st_q.p0_s1;
    if (port_wr) begin
      st_d.latch[port_sel] = port_wdata;
    end
    if (ext_bus_en) begin
      // Address first, then data on the same pins; push-pull for address and write data, released otherwise
      if (ext_addr_phase) begin
        st_d.p0_out = ext_addr[PORT_W-1:0];
        st_d.p0_oe  = 8'hff;
      end else if (ext_data_drive) begin
        st_d.p0_out = ext_wdata;
        st_d.p0_oe  = 8'hff;
      end else begin
        st_d.p0_out = 8'h00;
        st_d.p0_oe  = 8'h00;
      end
    end else begin
      // Open drain: only zeros are driven, ones float as inputs
      st_d.p0_out = 8'h00;
      st_d.p0_oe  = ~st_q.latch[PORT0];
    end

    p1_lvl = st_q.latch[PORT1];
    if (timer3_clkout_en) begin
      p1_lvl[T3_EVENT_BIT] = st_q.latch[PORT1][T3_EVENT_BIT] & timer3_clkout;
    end

    // Bus address drives strongly; the pull-up alone is too slow for address
    p2_lvl = ext_bus_en ? ext_addr[2*PORT_W-1:PORT_W] : st_q.latch[PORT2];
    p2_frc = {PORT_W{ext_bus_en}};

    p3_lvl          = st_q.latch[PORT3];
    p3_lvl[TXD_BIT] = st_q.latch[PORT3][TXD_BIT] & ~(uart_txd_en & ~uart_txd);
    p3_lvl[WR_BIT]  = st_q.latch[PORT3][WR_BIT] & ~ext_wr_strobe;
    p3_lvl[RD_BIT]  = st_q.latch[PORT3][RD_BIT] & ~ext_rd_strobe;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q.latch  <= {NUM_PORTS{LATCH_RST}};
      st_q.p0_out <= 8'h00;
      st_q.p0_oe  <= 8'h00;
      st_q.p0_s1  <= SYNC_RST;
      st_q.p0_s2  <= SYNC_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign p1_if.level        = p1_lvl;
  assign p1_if.force_strong = '0;
  assign p1_if.pin_in       = p1_in;
  assign p2_if.level        = p2_lvl;
  assign p2_if.force_strong = p2_frc;
  assign p2_if.pin_in       = p2_in;
  assign p3_if.level        = p3_lvl;
  assign p3_if.force_strong = '0;
  assign p3_if.pin_in       = p3_in;

  iop_quasi_port #(.W(PORT_W), .PULSE(STRONG_PULSE_CYC)) u_port1 (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .p       (p1_if.port)
  );

  iop_quasi_port #(.W(PORT_W), .PULSE(STRONG_PULSE_CYC)) u_port2 (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .p       (p2_if.port)
  );

  iop_quasi_port #(.W(PORT_W), .PULSE(STRONG_PULSE_CYC)) u_port3 (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .p       (p3_if.port)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Every output below is a flip-flop, here or inside a port instance
  assign p0_out                 = st_q.p0_out;
  assign p0_oe                  = st_q.p0_oe;
  assign p0_pins                = st_q.p0_s2;
  assign p1_out                 = p1_if.pin_out;
  assign p1_oe                  = p1_if.pin_oe;
  assign p1_pins                = p1_if.pin_sync;
  assign p2_out                 = p2_if.pin_out;
  assign p2_oe                  = p2_if.pin_oe;
  assign p2_pins                = p2_if.pin_sync;
  assign p3_out                 = p3_if.pin_out;
  assign p3_oe                  = p3_if.pin_oe;
  assign p3_pins                = p3_if.pin_sync;
  assign timer3_event_or_clkout = p1_if.pin_sync[T3_EVENT_BIT];
  assign timer3_ext_control     = p1_if.pin_sync[T3_CTRL_BIT];
  assign uart_rxd               = p3_if.pin_sync[RXD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_addr_phase;
    ext_bus_en && ext_addr_phase;
  endsequence
  sequence s_data_phase;
    ext_bus_en && !ext_addr_phase && ext_data_drive;
  endsequence
  sequence s_bus_idle;
    ext_bus_en && !ext_addr_phase && !ext_data_drive;
  endsequence

  a_p0_open_drain: assert property (!$past(ext_bus_en) |-> p0_out == 8'h00 && p0_oe == ~$past(st_q.latch[PORT0]))
    else $error("port 0 not open drain");
  a_p0_addr_data: assert property (s_addr_phase ##1 s_data_phase |=> p0_out == $past(ext_wdata) && p0_oe == 8'hff && $past(p0_out) == $past(ext_addr[7:0], 2))
    else $error("port 0 address then data sequence wrong");
  a_p2_high_addr: assert property (ext_bus_en |=> p2_out == $past(ext_addr[15:8]) && p2_oe == 8'hff)
    else $error("port 2 not emitting high address");
  a_t3_event_pin: assert property (timer3_event_or_clkout == $past(p1_in[T3_EVENT_BIT], 2))
    else $error("timer 3 event input not two-stage synchronised");
  a_t3_clk_out: assert property (timer3_clkout_en && !timer3_clkout |=> p1_oe[T3_EVENT_BIT] && !p1_out[T3_EVENT_BIT])
    else $error("timer 3 clock output low not driven");
  a_t3_control: assert property (timer3_ext_control == $past(p1_in[T3_CTRL_BIT], 2))
    else $error("timer 3 control input not synchronised");
  a_uart_pins: assert property ((uart_txd_en && !uart_txd |=> p3_oe[TXD_BIT] && !p3_out[TXD_BIT]) and (1'b1 |-> uart_rxd == $past(p3_in[RXD_BIT], 2)))
    else $error("serial pins wrong");
  a_ext_strobes: assert property ((ext_wr_strobe || ext_rd_strobe) |=> (!$past(ext_wr_strobe) || (p3_oe[WR_BIT] && !p3_out[WR_BIT])) && (!$past(ext_rd_strobe) || (p3_oe[RD_BIT] && !p3_out[RD_BIT])))
    else $error("external strobe not driven low");
  a_reset_ones: assert property (disable iff (1'b0) $rose(arst_n) |-> st_q.latch == {NUM_PORTS{LATCH_RST}} && p0_oe == 8'h00)
    else $error("port latches not all ones after reset");

  // Read phase: memory owns port 0, any drive from here would fight it
  a_p0_bus_float: assert property (s_bus_idle |=> p0_oe == 8'h00)
    else $error("port 0 not released while memory drives data");
  a_p0_addr_out: assert property (s_addr_phase |=> p0_out == $past(ext_addr[7:0]) && p0_oe == 8'hff)
    else $error("port 0 low address missing");
  a_p2_gpio_low: assert property (!ext_bus_en |=> (p2_oe & ~p2_out) == ~$past(st_q.latch[PORT2]))
    else $error("port 2 zero latch bits not driven low");
  a_p2_pins_sync: assert property (p2_pins == $past(p2_in, 2))
    else $error("port 2 input not two-stage synchronised");
  a_p3_pins_sync: assert property (p3_pins == $past(p3_in, 2))
    else $error("port 3 input not two-stage synchronised");
  a_wr_release: assert property ($fell(ext_wr_strobe) && st_q.latch[PORT3][WR_BIT]
    |=> p3_oe[WR_BIT] && p3_out[WR_BIT])
    else $error("write strobe release not driven high");
  a_rd_release: assert property ($fell(ext_rd_strobe) && st_q.latch[PORT3][RD_BIT]
    |=> p3_oe[RD_BIT] && p3_out[RD_BIT])
    else $error("read strobe release not driven high");
  a_txd_release: assert property ($fell(uart_txd_en && !uart_txd) && st_q.latch[PORT3][TXD_BIT]
    |=> p3_oe[TXD_BIT] && p3_out[TXD_BIT])
    else $error("serial transmit release not driven high");

endmodule : iop_ports

// File: bench/iop_pin_model.sv
// Far-side model: board pull-ups, external memory and pin level resolution
`timescale 1ns/1ps
module iop_pin_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p0_oe,
  input  wire logic [7:0] p1_out,
  input  wire logic [7:0] p1_oe,
  input  wire logic [7:0] p2_out,
  input  wire logic [7:0] p2_oe,
  input  wire logic [7:0] p3_out,
  input  wire logic [7:0] p3_oe,
  input  wire logic       mem_drive,
  input  wire logic [7:0] mem_data,
  input  wire logic [7:0] p1_low,
  input  wire logic [7:0] p3_low,
  output logic      [7:0] p0_in,
  output logic      [7:0] p1_in,
  output logic      [7:0] p2_in,
  output logic      [7:0] p3_in
);
  logic [7:0] float_q = 8'h55;

  ////////////////////////////////////////////////////////////////////////////////
  // No pull-up on port 0: a released pin must not look like a stable level
  always_ff @(posedge ref_clk) begin
    float_q <= ~float_q;
  end

  // Memory answers only while the device has let go of port 0
  assign p0_in = (p0_oe & p0_out) | (~p0_oe & (mem_drive ? mem_data : float_q));
  // Weak pull-ups lose against any board load pulling low
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & ~p1_low);
  assign p2_in = (p2_oe & p2_out) | ~p2_oe;
  assign p3_in = (p3_oe & p3_out) | (~p3_oe & ~p3_low);
endmodule : iop_pin_model

// File: bench/io_ports_ext_bus_mux_bench.sv
// Self-checking bench for the port pins and external bus multiplexing
`timescale 1ns/1ps
module io_ports_ext_bus_mux_bench;
  import iop_pkg::*;
  logic        ref_clk, arst_n, port_wr, ext_bus_en, ext_addr_phase, ext_data_drive;
  logic        ext_wr_strobe, ext_rd_strobe, timer3_clkout_en, timer3_clkout, uart_txd_en, uart_txd;
  logic [1:0]  port_sel;
  logic [7:0]  port_wdata, ext_wdata, mem_data, p1_low, p3_low;
  logic [15:0] ext_addr;
  logic        mem_drive;
  logic [7:0]  p0_in, p1_in, p2_in, p3_in, p0_out, p1_out, p2_out, p3_out;
  logic [7:0]  p0_oe, p1_oe, p2_oe, p3_oe, p0_pins, p1_pins, p2_pins, p3_pins;
  logic        timer3_event_or_clkout, timer3_ext_control, uart_rxd;
  int          error_cnt, comparisons;

  iop_ports dut (.ref_clk(ref_clk), .arst_n(arst_n), .port_wr(port_wr), .port_sel(port_sel),
    .port_wdata(port_wdata), .ext_bus_en(ext_bus_en), .ext_addr_phase(ext_addr_phase),
    .ext_addr(ext_addr), .ext_data_drive(ext_data_drive), .ext_wdata(ext_wdata),
    .ext_wr_strobe(ext_wr_strobe), .ext_rd_strobe(ext_rd_strobe), .timer3_clkout_en(timer3_clkout_en),
    .timer3_clkout(timer3_clkout), .uart_txd_en(uart_txd_en), .uart_txd(uart_txd),
    .p0_in(p0_in), .p1_in(p1_in), .p2_in(p2_in), .p3_in(p3_in), .p0_out(p0_out), .p0_oe(p0_oe),
    .p1_out(p1_out), .p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe), .p3_out(p3_out), .p3_oe(p3_oe),
    .p0_pins(p0_pins), .p1_pins(p1_pins), .p2_pins(p2_pins), .p3_pins(p3_pins),
    .timer3_event_or_clkout(timer3_event_or_clkout), .timer3_ext_control(timer3_ext_control),
    .uart_rxd(uart_rxd));

  iop_pin_model model (.ref_clk(ref_clk), .p0_out(p0_out), .p0_oe(p0_oe), .p1_out(p1_out),
    .p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe), .p3_out(p3_out), .p3_oe(p3_oe),
    .mem_drive(mem_drive), .mem_data(mem_data), .p1_low(p1_low), .p3_low(p3_low),
    .p0_in(p0_in), .p1_in(p1_in), .p2_in(p2_in), .p3_in(p3_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Three falling edges: outputs and two-flop input syncs have all settled
  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask : settle

  task automatic wr_port(input logic [1:0] sel, input logic [7:0] data);
    port_wr    = 1'b1;
    port_sel   = sel;
    port_wdata = data;
    @(negedge ref_clk);
    port_wr    = 1'b0;
  endtask : wr_port

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(p0_oe, 8'h00, "p0 oe after reset");
    check(p1_oe | p2_oe | p3_oe, 8'h00, "p1-p3 oe after reset");
    check(p1_pins & p2_pins & p3_pins, 8'hff, "pins after reset");
    check({timer3_event_or_clkout, timer3_ext_control, uart_rxd}, 8'h07, "alt inputs after reset");
  endtask : t_reset

  task automatic t_open_drain();
    wr_port(PORT0, 8'h5a);
    settle();
    check(p0_oe, 8'ha5, "p0 oe for 5a");
    check(p0_out, 8'h00, "p0 out level");
    wr_port(PORT0, 8'hff);
    settle();
    check(p0_oe, 8'h00, "p0 released");
  endtask : t_open_drain

  // Counts the strong-high cycles instead of fixing their start edge
  task automatic t_pulse(input logic [1:0] sel);
    logic [7:0] cnt;
    cnt = 8'h00;
    wr_port(sel, 8'h00);
    settle();
    check(sel == PORT1 ? p1_oe & ~p1_out : p3_oe & ~p3_out, 8'hff, "driven low");
    wr_port(sel, 8'hff);
    repeat (6) begin
      @(negedge ref_clk);
      if ((sel == PORT1 ? p1_oe & p1_out : p3_oe & p3_out) === 8'hff) cnt++;
    end
    check(cnt, 8'(STRONG_PULSE_CYC), "strong high cycles");
    check(sel == PORT1 ? p1_oe : p3_oe, 8'h00, "weak after pulse");
  endtask : t_pulse

  task automatic t_p2_gpio();
    wr_port(PORT2, 8'h0f);
    settle();
    check(p2_oe & ~p2_out, 8'hf0, "p2 zeros driven low");
    check(p2_pins, 8'h0f, "p2 pins read back");
    wr_port(PORT2, 8'hff);
    settle();
    settle();
    check(p2_oe, 8'h00, "p2 weak after ones");
  endtask : t_p2_gpio

  task automatic t_bus();
    {ext_bus_en, ext_addr_phase, ext_addr} = {2'b11, 16'h3c96};
    settle();
    check(p0_out & p0_oe, 8'h96, "low address");
    check(p0_oe, 8'hff, "low address drive");
    check(p2_out & p2_oe, 8'h3c, "high address");
    {ext_addr_phase, ext_data_drive, ext_wdata} = {2'b01, 8'ha7};
    settle();
    check(p0_out & p0_oe, 8'ha7, "write data");
    check(p2_out & p2_oe, 8'h3c, "high address held");
    {ext_data_drive, mem_drive, mem_data} = {2'b01, 8'h81};
    settle();
    check(p0_oe, 8'h00, "read releases p0");
    check(p0_pins, 8'h81, "read data");
    {ext_bus_en, mem_drive} = 2'b00;
    settle();
    settle();
    check(p2_oe, 8'h00, "p2 weak after bus");
    check(p2_pins, 8'hff, "p2 pulled up");
  endtask : t_bus

  task automatic t_alt();
    {p1_low, p3_low} = {8'h03, 8'h01};
    settle();
    check(timer3_event_or_clkout, 8'h00, "timer event in");
    check(timer3_ext_control, 8'h00, "timer control in");
    check(uart_rxd, 8'h00, "serial receive");
    {p1_low, p3_low} = 16'h0000;
    {timer3_clkout_en, timer3_clkout, uart_txd_en, uart_txd} = 4'b1010;
    {ext_wr_strobe, ext_rd_strobe} = 2'b11;
    settle();
    check({p1_oe[0], p1_out[0]}, 8'h02, "timer clock out low");
    check({p3_oe[1], p3_out[1]}, 8'h02, "serial transmit low");
    check({p3_oe[7:6], p3_out[7:6]}, 8'h0c, "strobes low");
    {timer3_clkout_en, uart_txd_en, ext_wr_strobe, ext_rd_strobe} = 4'b0000;
    settle();
    settle();
    check(p1_oe | p3_oe, 8'h00, "alt outputs weak high");
  endtask : t_alt

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Whole run is under a hundred cycles; four thousand means a hang
  initial begin
    #(25 * 4000);
    error_cnt++;
    close_out();
  end

  initial begin
    {arst_n, port_wr, port_sel, port_wdata, ext_bus_en, ext_addr_phase, ext_addr} = '0;
    {ext_data_drive, ext_wdata, ext_wr_strobe, ext_rd_strobe, mem_drive, mem_data} = '0;
    {timer3_clkout_en, timer3_clkout, uart_txd_en, uart_txd, p1_low, p3_low} = '0;
    error_cnt   = 0;
    comparisons = 0;
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    settle();
    t_reset();
    t_open_drain();
    t_pulse(PORT1);
    t_pulse(PORT3);
    t_p2_gpio();
    t_bus();
    t_alt();
    close_out();
  end
endmodule : io_ports_ext_bus_mux_bench
